// ---- logic/fla_arbiter.sv ----
/*
 * four level interrupt arbiter: enables, priorities, request flags,
 * arbitration at instruction boundaries and hardware call insertion.
 * assumes the core marks the last cycle of each instruction, flags the
 * return and enable/priority writes, and runs a call when asked.
 */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Functional notes
// - two bits per source give level zero lowest up to three highest.
// - running routine is preempted only by a strictly higher level request.
// - at a boundary the highest pending level wins.
// - same-level ties go to the lowest vector address.
// - sample requests at instruction end using last cycle's registered flags.
// - enabled unblocked request makes a long call the next instruction.
// - return or enable/priority write suppresses vectoring for one instruction.
// - blocked requests are not remembered; each sample is fresh.
// - hardware call takes four cycles, five or more to handler.
// - mid-instruction wait at most four cycles, nine after return.
// - single-source latency is above five and below fourteen cycles.
// - each external input is level or edge by its select bit.
// - external flag cleared on vectoring only in edge mode.
// - timer overflow flags cleared on vectoring; peripheral flags follow their request lines.
// - global enable masks all; otherwise per-source enable applies.
// - software flag writes act like hardware updates.
// - each source owns a distinct vector near program start.
module fla_arbiter #(
	parameter int N = fla_pkg::NUM_SRC
) (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// request sources
	input  wire logic        ext_irq0_pin,
	input  wire logic        ext_irq1_pin,
	input  wire logic        timer0_rollover,
	input  wire logic        timer1_rollover,
	input  wire logic [N-1:0] periph_req,
	// core sequencer
	input  wire logic        instr_last_cycle,
	input  wire logic        instr_is_return_from_irq_instr,
	input  wire logic        instr_writes_irq_cfg,
	output logic             long_call_req,
	output logic      [15:0] long_call_vector,
	output logic             call_busy,
	// interrupt line
	output logic             irq
);
	import fla_pkg::*;

	logic [7:0]     irq_enable_reg0_q;
	logic [7:0]     prio_low_q;
	logic [7:0]     prio_high_q;
	logic [N-1:0]   flag_q;
	logic [1:0]     edge_sel_q;
	logic [1:0]     pin_q;
	logic [3:0]     active_lvl_q;
	logic [EV_WIDTH-1:0] ev_stat_q;
	logic [EV_WIDTH-1:0] ev_en_q;
	fla_state_e     state_q;
	logic [2:0]     call_cnt_q;
	logic [15:0]    vec_q;
	logic [$clog2(N)-1:0] win_idx_q;
	logic [3:0]     wait_cnt_q;

	logic           wr_en;
	logic           rd_en;
	logic [N-1:0]   req;
	logic [N-1:0]   sw_wr_mask;
	logic [1:0]     lvl [N];
	logic [1:0]     best_lvl;
	logic [$clog2(N)-1:0] best_idx;
	logic           found;
	logic           cur_hi_valid;
	logic [1:0]     cur_hi;
	logic           take;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// per-source level and gated request
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			assign lvl[g] = {prio_high_q[g], prio_low_q[g]};
			assign req[g] = flag_q[g] & irq_enable_reg0_q[BIT_GLOBAL_EN]
				& irq_enable_reg0_q[g];
		end
	endgenerate

	// highest level first, lowest index (vector) within the level
	always_comb begin
		best_lvl = 2'b00;
		best_idx = '0;
		found    = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && (!found || lvl[i] >= best_lvl)) begin
				best_lvl = lvl[i];
				best_idx = ($clog2(N))'(i);
				found    = 1'b1;
			end
		end
	end

	always_comb begin
		cur_hi_valid = |active_lvl_q;
		cur_hi       = 2'b00;
		for (int l = 0; l < 4; l++) begin
			if (active_lvl_q[l])
				cur_hi = 2'(l);
		end
	end

	// flags are the registered view, so sampling sees last cycle's value
	assign take = (state_q == FLA_IDLE) & instr_last_cycle & found
		& ~instr_is_return_from_irq_instr & ~instr_writes_irq_cfg
		& (~cur_hi_valid | (best_lvl > cur_hi));

	// apb register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg0_q <= RST_BYTE;
			prio_low_q        <= RST_BYTE;
			prio_high_q       <= RST_BYTE;
			edge_sel_q        <= 2'b00;
			ev_en_q           <= '0;
		end else if (wr_en) begin
			case (paddr)
			OFF_ENABLE0:    irq_enable_reg0_q <= pwdata[7:0];
			OFF_PRIO_LOW:   prio_low_q        <= pwdata[7:0];
			OFF_PRIO_HIGH:  prio_high_q       <= pwdata[7:0];
			OFF_EDGE_SEL:   edge_sel_q        <= pwdata[1:0];
			OFF_IRQ_ENABLE: ev_en_q           <= pwdata[EV_WIDTH-1:0];
			default: ;
			endcase
		end
	end

	assign sw_wr_mask = (wr_en && paddr == OFF_FLAGS) ? '1 : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_q <= 2'b11;
		else
			pin_q <= {ext_irq1_pin, ext_irq0_pin};
	end

	// request flags: hardware set beats vector clear; software write beats both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (sw_wr_mask[i])
					flag_q[i] <= pwdata[i];
				else if (i == SRC_EXT0 || i == SRC_EXT1) begin
					automatic int e = (i == SRC_EXT0) ? 0 : 1;
					automatic logic pin = (e == 0) ? ext_irq0_pin
						: ext_irq1_pin;
					if (!edge_sel_q[e])
						flag_q[i] <= ~pin;
					else if (pin_q[e] & ~pin)
						flag_q[i] <= 1'b1;
					else if (take && best_idx == i)
						flag_q[i] <= 1'b0;
				end else if (i == SRC_TMR0 || i == SRC_TMR1) begin
					if ((i == SRC_TMR0) ? timer0_rollover : timer1_rollover)
						flag_q[i] <= 1'b1;
					else if (take && best_idx == i)
						flag_q[i] <= 1'b0;
				end else begin
					flag_q[i] <= periph_req[i];
				end
			end
		end
	end

	// call sequencer: request, four-cycle call, then handler starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= FLA_IDLE;
			call_cnt_q <= 3'd0;
			vec_q      <= 16'h0000;
			win_idx_q  <= '0;
		end else begin
			case (state_q)
			FLA_IDLE: begin
				if (take) begin
					state_q    <= FLA_CALL;
					call_cnt_q <= CALL_CYC - 3'd1;
					win_idx_q  <= best_idx;
					vec_q      <= VEC_BASE
						+ 16'(best_idx) * VEC_STEP;
				end
			end
			FLA_CALL: begin
				if (call_cnt_q == 3'd1)
					state_q <= FLA_DONE;
				call_cnt_q <= call_cnt_q - 3'd1;
			end
			FLA_DONE: state_q <= FLA_IDLE;
			default:  state_q <= FLA_IDLE;
			endcase
		end
	end

	assign long_call_req    = state_q == FLA_CALL
		&& call_cnt_q == CALL_CYC - 3'd1;
	assign long_call_vector = vec_q;
	assign call_busy        = state_q != FLA_IDLE;

	// active levels: set on acceptance, highest cleared on return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_lvl_q <= 4'h0;
		end else if (take) begin
			active_lvl_q[best_lvl] <= 1'b1;
		end else if (instr_is_return_from_irq_instr && instr_last_cycle && cur_hi_valid) begin
			active_lvl_q[cur_hi] <= 1'b0;
		end
	end

	// event status: set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_stat_q <= '0;
		end else begin
			for (int b = 0; b < EV_WIDTH; b++) begin
				if ((b == EV_VECTOR && take) || (b == EV_RETURN
					&& instr_is_return_from_irq_instr && instr_last_cycle))
					ev_stat_q[b] <= 1'b1;
				else if (wr_en && paddr == OFF_IRQ_CLEAR && pwdata[b])
					ev_stat_q[b] <= 1'b0;
			end
		end
	end

	assign irq = |(ev_stat_q & ev_en_q);

	// cycles an open request has waited while idle; a return adds at most
	// one more instruction, so the wait stays within the response window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_cnt_q <= 4'h0;
		else if (state_q != FLA_IDLE || !found || take
			|| (cur_hi_valid && best_lvl <= cur_hi))
			wait_cnt_q <= 4'h0;
		else if (wait_cnt_q != 4'hF)
			wait_cnt_q <= wait_cnt_q + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !penable) begin
			case (paddr)
			OFF_ENABLE0:    prdata <= {24'h0, irq_enable_reg0_q};
			OFF_PRIO_LOW:   prdata <= {24'h0, prio_low_q};
			OFF_PRIO_HIGH:  prdata <= {24'h0, prio_high_q};
			OFF_FLAGS:      prdata <= 32'(flag_q);
			OFF_EDGE_SEL:   prdata <= {30'h0, edge_sel_q};
			OFF_STATUS:     prdata <= 32'(ev_stat_q);
			OFF_IRQ_ENABLE: prdata <= 32'(ev_en_q);
			OFF_ACTIVE:     prdata <= {28'h0, active_lvl_q};
			default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	a_preempt_strict: assert property (@(posedge pclk) disable iff (!presetn)
		take && cur_hi_valid |-> best_lvl > cur_hi)
		else $error("preempted by level not above active one");
	a_block_return_from_irq_instr: assert property (@(posedge pclk) disable iff (!presetn)
		instr_is_return_from_irq_instr || instr_writes_irq_cfg |-> !take)
		else $error("vectored during blocking instruction");
	a_call_length: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(long_call_req) |-> call_busy [*4] ##1 !call_busy)
		else $error("call length is not four cycles");
	a_global_mask: assert property (@(posedge pclk) disable iff (!presetn)
		!irq_enable_reg0_q[BIT_GLOBAL_EN] |-> !take)
		else $error("vectored while globally masked");
	a_call_follows: assert property (@(posedge pclk) disable iff (!presetn)
		take |=> long_call_req && vec_q == VEC_BASE
			+ 16'($past(best_idx)) * VEC_STEP)
		else $error("call did not follow acceptance");
	a_tmr_clear: assert property (@(posedge pclk) disable iff (!presetn)
		take && best_idx == SRC_TMR0 && !timer0_rollover
		&& !sw_wr_mask[SRC_TMR0] |=> !flag_q[SRC_TMR0])
		else $error("timer flag not cleared on vectoring");
	a_highest_wins: assert property (@(posedge pclk) disable iff (!presetn)
		take |-> !(req[0] && lvl[0] > best_lvl))
		else $error("lower level chosen");
	a_level_track: assert property (@(posedge pclk) disable iff (!presetn)
		take |=> active_lvl_q[$past(best_lvl)])
		else $error("accepted level not marked active");
	a_tie_order: assert property (@(posedge pclk) disable iff (!presetn)
		take && best_idx != 0 |-> !(req[0] && lvl[0] == best_lvl))
		else $error("tie not resolved by vector order");

	// flag paths of the external and timer sources, then level release, vector grid and wait bound
	a_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
		!edge_sel_q[0] && !sw_wr_mask[SRC_EXT0]
		|=> flag_q[SRC_EXT0] == !$past(ext_irq0_pin))
		else $error("level flag does not follow its pin");
	a_ext_set: assert property (@(posedge pclk) disable iff (!presetn)
		edge_sel_q[0] && pin_q[0] && !ext_irq0_pin
		&& !sw_wr_mask[SRC_EXT0] |=> flag_q[SRC_EXT0])
		else $error("falling edge did not set flag");
	a_edge_clear: assert property (@(posedge pclk) disable iff (!presetn)
		edge_sel_q[0] && take && best_idx == SRC_EXT0
		&& !(pin_q[0] && !ext_irq0_pin) && !sw_wr_mask[SRC_EXT0]
		|=> !flag_q[SRC_EXT0])
		else $error("edge flag not cleared on vectoring");
	a_tmr1_clear: assert property (@(posedge pclk) disable iff (!presetn)
		take && best_idx == SRC_TMR1 && !timer1_rollover
		&& !sw_wr_mask[SRC_TMR1] |=> !flag_q[SRC_TMR1])
		else $error("timer one flag not cleared on vectoring");
	a_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
		sw_wr_mask[SRC_TMR1]
		|=> flag_q[SRC_TMR1] == $past(pwdata[SRC_TMR1]))
		else $error("software flag write lost");
	a_ret_release: assert property (@(posedge pclk) disable iff (!presetn)
		instr_is_return_from_irq_instr && instr_last_cycle && cur_hi_valid
		|=> !active_lvl_q[$past(cur_hi)])
		else $error("return did not release highest level");
	a_vector_map: assert property (@(posedge pclk) disable iff (!presetn)
		long_call_req |-> long_call_vector[2:0] == VEC_BASE[2:0])
		else $error("vector off the vector grid");
	a_resp_window: assert property (@(posedge pclk) disable iff (!presetn)
		wait_cnt_q <= 4'(RESP_MAX - RESP_MIN))
		else $error("request waited beyond the response window");
endmodule

// ---- logic/fla_pkg.sv ----
/*
 * package of the four level interrupt arbiter: register map, field layout,
 * vector table, timing figures.
 * assumes a 20 MHz apb clock and 32-bit data words.
 */
package fla_pkg;
	localparam int NUM_SRC = 8;
	localparam int CLK_NS = 50;
	// register byte offsets; the enable register keeps its printed offset
	localparam logic [7:0] OFF_ENABLE0    = 8'hA8;
	localparam logic [7:0] OFF_PRIO_LOW   = 8'hB8;
	localparam logic [7:0] OFF_PRIO_HIGH  = 8'hB4;
	localparam logic [7:0] OFF_FLAGS      = 8'h88;
	localparam logic [7:0] OFF_EDGE_SEL   = 8'h8C;
	localparam logic [7:0] OFF_STATUS     = 8'hC0;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'hC4;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'hC8;
	localparam logic [7:0] OFF_ACTIVE     = 8'hCC;
	localparam logic [7:0] RST_BYTE       = 8'h00;
	// bit positions inside the enable register and the flag register
	localparam int BIT_GLOBAL_EN = 7;
	localparam int SRC_EXT0 = 0;
	localparam int SRC_TMR0 = 1;
	localparam int SRC_EXT1 = 2;
	localparam int SRC_TMR1 = 3;
	// status bits of the event register
	localparam int EV_VECTOR = 0;
	localparam int EV_RETURN = 1;
	localparam int EV_WIDTH  = 2;
	// hardware call length and response window
	localparam int CALL_NS = 200;
	localparam logic [2:0] CALL_CYC = 3'(CALL_NS / CLK_NS);
	localparam int RESP_MIN = 5;
	localparam int RESP_MAX = 14;
	// vector addresses in source (polling) order
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	typedef enum logic [1:0] {
		FLA_IDLE = 2'b00,
		FLA_CALL = 2'b01,
		FLA_DONE = 2'b11
	} fla_state_e;
endpackage

// ---- testbench/fla_core_model.sv ----
/*
 * core sequencer model: fixed-length instructions, last-cycle marker,
 * return instruction on request, paused while the inserted call runs.
 * assumes the arbiter drives call_busy for the whole hardware call.
 */
`timescale 1ns/1ps
module fla_core_model #(
	parameter int ILEN = 3
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// arbiter side
	input  wire logic call_busy,
	input  wire logic return_from_irq_instr_req,
	output logic      instr_last_cycle,
	output logic      instr_is_return_from_irq_instr,
	output logic      instr_writes_irq_cfg
);
	logic [2:0] cnt_q;

	// instructions stay within the five-cycle longest length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
		end else if (call_busy || cnt_q == 3'(ILEN - 1)) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	assign instr_last_cycle = !call_busy && cnt_q == 3'(ILEN - 1);
	// return marked on an instruction's last cycle while one is requested
	assign instr_is_return_from_irq_instr = instr_last_cycle && return_from_irq_instr_req;
	assign instr_writes_irq_cfg = 1'b0;
endmodule

// ---- testbench/test_four_level_irq_arbiter.sv ----
/*
 * self-checking testbench of the four level arbiter over apb.
 * assumes fla_core_model paces instructions and zero-wait apb slave.
 */
`timescale 1ns/1ps
module test_four_level_irq_arbiter;
	import fla_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pin0, tr0, ilast, ireti, icfg, lreq, busy, irq, rreq;
	logic [15:0] lvec;
	int          errors, compares;

	fla_arbiter u_fla_arbiter (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_irq0_pin(pin0), .ext_irq1_pin(1'b1), .timer0_rollover(tr0),
		.timer1_rollover(1'b0), .periph_req(8'h00), .instr_last_cycle(ilast),
		.instr_is_return_from_irq_instr(ireti), .instr_writes_irq_cfg(icfg),
		.long_call_req(lreq), .long_call_vector(lvec), .call_busy(busy),
		.irq(irq));
	fla_core_model u_fla_core_model (.pclk(pclk), .presetn(presetn),
		.call_busy(busy), .return_from_irq_instr_req(rreq), .instr_last_cycle(ilast),
		.instr_is_return_from_irq_instr(ireti), .instr_writes_irq_cfg(icfg));

	task automatic report_and_stop;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_call(input logic [15:0] e);
		repeat (60) begin
			@(posedge pclk);
			if (lreq === 1'b1) break;
		end
		chk({15'h0, lreq, lvec}, {15'h0, 1'b1, e});
	endtask

	task automatic no_call(input int n);
		int hits;
		hits = 0;
		repeat (n) begin
			@(posedge pclk);
			if (lreq !== 1'b0) hits++;
		end
		chk(32'(hits), 32'h0);
	endtask

	task automatic return_from_irq_instr;
		@(posedge pclk);
		rreq <= 1'b1;
		repeat (30) begin
			@(posedge pclk);
			if (ireti === 1'b1) break;
		end
		rreq <= 1'b0;
	endtask

	task automatic s_reset;
		apb(1'b0, OFF_ENABLE0, 32'h0, rd);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h0);
		chk({30'h0, pready, pslverr}, 32'h2);
	endtask

	// edge mode: a short low pulse is latched and cleared on vectoring
	task automatic s_edge;
		apb(1'b1, OFF_EDGE_SEL, 32'h01, rd);
		apb(1'b1, OFF_ENABLE0, 32'h81, rd);
		pin0 <= 1'b0;
		@(posedge pclk);
		pin0 <= 1'b1;
		wait_call(VEC_BASE);
		apb(1'b0, OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h00);
		return_from_irq_instr();
	endtask

	// same level: timer zero before timer one, timer zero flag self-clears
	task automatic s_tie;
		apb(1'b1, OFF_FLAGS, 32'h08, rd);
		tr0 <= 1'b1;
		@(posedge pclk);
		tr0 <= 1'b0;
		apb(1'b1, OFF_ENABLE0, 32'h8A, rd);
		wait_call(16'h000B);
		apb(1'b0, OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h08);
		return_from_irq_instr();
		wait_call(16'h001B);
		return_from_irq_instr();
	endtask

	// level three wins and holds off level zero until it returns
	task automatic s_prio;
		apb(1'b1, OFF_ENABLE0, 32'h00, rd);
		apb(1'b1, OFF_PRIO_LOW, 32'h08, rd);
		apb(1'b1, OFF_PRIO_HIGH, 32'h08, rd);
		pin0 <= 1'b0;
		apb(1'b1, OFF_FLAGS, 32'h08, rd);
		apb(1'b1, OFF_ENABLE0, 32'h89, rd);
		wait_call(16'h001B);
		no_call(20);
		return_from_irq_instr();
		wait_call(VEC_BASE);
		apb(1'b0, OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h01);
		pin0 <= 1'b1;
		return_from_irq_instr();
	endtask

	task automatic s_mask;
		apb(1'b1, OFF_ENABLE0, 32'h02, rd);
		apb(1'b1, OFF_FLAGS, 32'h02, rd);
		no_call(20);
		apb(1'b1, OFF_ENABLE0, 32'h82, rd);
		wait_call(16'h000B);
		return_from_irq_instr();
	endtask

	task automatic s_irq;
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFF_IRQ_ENABLE, 32'h01, rd);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFF_IRQ_CLEAR, 32'h03, rd);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
	endtask

	initial begin
		pclk = 1'b0;
		forever #(CLK_NS / 2) pclk = ~pclk;
	end

	// whole run is under two hundred cycles
	initial begin
		#(CLK_NS * 5000);
		errors++;
		report_and_stop();
	end

	initial begin
		{presetn, psel, penable, pwrite, tr0, rreq} = 6'h00;
		pin0 = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		compares = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		s_reset();
		s_tie();
		s_prio();
		s_mask();
		s_edge();
		s_irq();
		report_and_stop();
	end
endmodule
